// ==== verilog/servo_pkg.sv ====
package servo_pkg;
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          PERIOD_MS       = 16;
  localparam int          PERIOD_CYC      = CLK_HZ / 1000 * PERIOD_MS;
  localparam int          POS_W           = 8;
  localparam int          PWR_W           = 8;
  localparam logic [7:0]  PWR_MAX         = 8'h7F;
  localparam logic [7:0]  STALL_PCT       = 8'h19;
  localparam logic [7:0]  PCT_FULL        = 8'h64;
  localparam logic [7:0]  GAIN_RST        = 8'h01;
  localparam int          FLASH_HALF_CYC  = 6_250_000;
  localparam logic [1:0]  CH1_AIN_DEFAULT = 2'h0;
  typedef enum logic [1:0] {RUNNING, STOPPED, FAULTED} run_e;
endpackage

// ==== verilog/position_servo_fault_supervisor.sv ====
// Summary of operation
// - single-channel with analog command takes command from ain1 and feedback from ain4.
// - single-channel variant uses one command and one feedback input only.
// - a nonzero position error with nonzero gain drives power in the direction that closes it, until zero.
// - zero error means zero applied power and no motion.
// - power magnitude of at least 25 percent with no encoder motion flags a fault.
// - an encoder fault halts all motor output until reset.
// - a latched encoder fault flashes the diagnostic led rapidly.
// - an active emergency stop removes motor output for as long as it is held.
// - an emergency stop disables both channels.
// - both front-panel buttons pressed together act as an emergency stop.
// - the loop samples position and computes error once every 16 ms period.
// - dual-channel feedback is ain1/ain2, or ain3/ain4 in analog command mode.
module position_servo_fault_supervisor #(
  parameter int PERIOD_CYC     = servo_pkg::PERIOD_CYC,
  parameter int FLASH_HALF_CYC = servo_pkg::FLASH_HALF_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              single_channel_variant,
  input  wire logic              analog_cmd_mode,
  input  wire logic signed [7:0] ain1,
  input  wire logic signed [7:0] ain2,
  input  wire logic signed [7:0] ain3,
  input  wire logic signed [7:0] ain4,
  input  wire logic signed [7:0] dest1,
  input  wire logic signed [7:0] dest2,
  input  wire logic [7:0]        gain,
  input  wire logic              enc1_motion,
  input  wire logic              enc2_motion,
  input  wire logic              estop_in,
  input  wire logic              btn_program,
  input  wire logic              btn_set,
  output logic signed [7:0]      pwr1_r,
  output logic signed [7:0]      pwr2_r,
  output logic                   motors_en_r,
  output logic                   enc_fault_r,
  output logic                   led_r,
  output logic                   tick_r
);
  // estop, button, encoder and ain pins cross two flops; mode, dest and gain pins do not; ain buses assumed held stable by the sampling adc
  logic [1:0] es_s, bp_s, bs_s, m1_s, m2_s;
  logic signed [7:0] a1_q, a2_q, a3_q, a4_q, a1_r, a2_r, a3_r, a4_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      es_s <= 2'h0;
      bp_s <= 2'h0;
      bs_s <= 2'h0;
      m1_s <= 2'h0;
      m2_s <= 2'h0;
      a1_q <= 8'sh00; a2_q <= 8'sh00; a3_q <= 8'sh00; a4_q <= 8'sh00;
      a1_r <= 8'sh00; a2_r <= 8'sh00; a3_r <= 8'sh00; a4_r <= 8'sh00;
    end else begin
      es_s <= {es_s[0], estop_in};
      bp_s <= {bp_s[0], btn_program};
      bs_s <= {bs_s[0], btn_set};
      m1_s <= {m1_s[0], enc1_motion};
      m2_s <= {m2_s[0], enc2_motion};
      a1_q <= ain1; a2_q <= ain2; a3_q <= ain3; a4_q <= ain4;
      a1_r <= a1_q; a2_r <= a2_q; a3_r <= a3_q; a4_r <= a4_q;
    end
  end

  // motion seen anywhere within the period; sticky until the tick samples it
  logic mot1_r, mot2_r;
  logic [31:0] per_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      per_cnt_r <= 32'h0;
      tick_r    <= 1'b0;
    end else if (per_cnt_r == 32'(PERIOD_CYC - 1)) begin
      per_cnt_r <= 32'h0;
      tick_r    <= 1'b1;
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
      tick_r    <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mot1_r <= 1'b0;
      mot2_r <= 1'b0;
    end else if (tick_r) begin
      mot1_r <= m1_s[1];
      mot2_r <= m2_s[1];
    end else begin
      mot1_r <= mot1_r | m1_s[1];
      mot2_r <= mot2_r | m2_s[1];
    end
  end

  function automatic logic signed [7:0] drive(input logic signed [7:0] d,
                                               input logic signed [7:0] p,
                                               input logic [7:0] g);
    logic signed [17:0] e;
    e = 18'(d) - 18'(p);
    e = e * $signed({1'b0, g});
    if (e > 18'sh7F) e = 18'sh7F;
    if (e < -18'sh7F) e = -18'sh7F;
    return e[7:0];
  endfunction
  function automatic logic [7:0] mag(input logic signed [7:0] v);
    return v[7] ? 8'(-v) : 8'(v);
  endfunction

  logic signed [7:0] fb1, fb2, cmd1, cmd2, p1_nxt, p2_nxt;
  always_comb begin
    cmd1 = dest1;
    cmd2 = dest2;
    if (single_channel_variant) begin
      if (analog_cmd_mode) cmd1 = a1_r;
      fb1 = analog_cmd_mode ? a4_r : a1_r;
      fb2 = 8'sh00;
      cmd2 = 8'sh00;
    end else begin
      if (analog_cmd_mode) begin
        cmd1 = a1_r;
        cmd2 = a2_r;
      end
      fb1 = analog_cmd_mode ? a3_r : a1_r;
      fb2 = analog_cmd_mode ? a4_r : a2_r;
    end
    p1_nxt = drive(cmd1, fb1, gain);
    p2_nxt = single_channel_variant ? 8'sh00 : drive(cmd2, fb2, gain);
  end

  // 25 percent of full scale, rounded up
  localparam logic [15:0] THR = 16'((32'(servo_pkg::PWR_MAX) * 32'(servo_pkg::STALL_PCT)
                                    + 32'(servo_pkg::PCT_FULL) - 1) / 32'(servo_pkg::PCT_FULL));
  logic stop_now;
  assign stop_now = es_s[1] | (bp_s[1] & bs_s[1]);
  // judged only at ticks, so a short load spike between ticks cannot trip it
  logic stall;
  assign stall = tick_r && ((16'(mag(pwr1_r)) >= THR && !mot1_r) ||
                            (16'(mag(pwr2_r)) >= THR && !mot2_r));

  // no clear path short of reset: a seized shaft must never restart by itself
  always_ff @(posedge clk_sys) begin
    if (rst) enc_fault_r <= 1'b0;
    else if (stall) enc_fault_r <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwr1_r      <= 8'sh00;
      pwr2_r      <= 8'sh00;
      motors_en_r <= 1'b0;
    end else if (enc_fault_r || stall || stop_now) begin
      pwr1_r      <= 8'sh00;
      pwr2_r      <= 8'sh00;
      motors_en_r <= 1'b0;
    end else if (tick_r) begin
      pwr1_r      <= p1_nxt;
      pwr2_r      <= p2_nxt;
      motors_en_r <= 1'b1;
    end
  end

  // counter parked at zero while healthy so the first flash gets a full half period
  logic [31:0] fl_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (rst || !enc_fault_r) begin
      fl_cnt_r <= 32'h0;
      led_r    <= 1'b0;
    end else if (fl_cnt_r == 32'(FLASH_HALF_CYC - 1)) begin
      fl_cnt_r <= 32'h0;
      led_r    <= ~led_r;
    end else begin
      fl_cnt_r <= fl_cnt_r + 32'h1;
    end
  end

  // checks watch registered design state and the unsynchronised mode, dest and gain pins directly
  AST_FAULT_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
    enc_fault_r |=> enc_fault_r) else $error("fault cleared without reset");
  AST_FAULT_NO_PWR: assert property (@(posedge clk_sys) disable iff (rst)
    enc_fault_r |-> pwr1_r == 0 && pwr2_r == 0) else $error("power while faulted");
  AST_HALT_EN: assert property (@(posedge clk_sys) disable iff (rst)
    enc_fault_r |-> !motors_en_r) else $error("motors enabled while faulted");
  AST_ESTOP: assert property (@(posedge clk_sys) disable iff (rst)
    es_s[1] |=> pwr1_r == 0 && pwr2_r == 0 && !motors_en_r) else $error("estop ignored");
  AST_BOTH_CH: assert property (@(posedge clk_sys) disable iff (rst)
    stop_now |=> pwr1_r == 0 && pwr2_r == 0) else $error("channel left driven on stop");
  AST_BUTTONS: assert property (@(posedge clk_sys) disable iff (rst)
    bp_s[1] && bs_s[1] |=> !motors_en_r) else $error("button stop ignored");
  AST_STALL: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && !mot1_r && 16'(mag(pwr1_r)) >= THR |=> enc_fault_r) else $error("stall missed");
  AST_STALL2: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && !mot2_r && 16'(mag(pwr2_r)) >= THR |=> enc_fault_r) else $error("stall 2 missed");
  AST_NO_FALSE: assert property (@(posedge clk_sys) disable iff (rst)
    !enc_fault_r && !tick_r |=> !enc_fault_r) else $error("fault off tick");
  AST_UPDATE_TICK: assert property (@(posedge clk_sys) disable iff (rst)
    !$stable(pwr1_r) && pwr1_r != 0 |-> $past(tick_r)) else $error("update off tick");
  AST_TICK_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r |=> !tick_r) else $error("tick longer than one cycle");
  AST_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && !stop_now && !enc_fault_r && !stall && cmd1 > fb1 && gain != 0
    |=> pwr1_r > 0) else $error("wrong direction");
  AST_DIR_NEG: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && !stop_now && !enc_fault_r && !stall && cmd1 < fb1 && gain != 0
    |=> pwr1_r < 0) else $error("wrong reverse direction");
  AST_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && cmd1 == fb1 |=> pwr1_r == 0) else $error("power at zero error");
  AST_SC_CH2: assert property (@(posedge clk_sys) disable iff (rst)
    single_channel_variant && tick_r |=> pwr2_r == 0) else $error("sc ch2 driven");
  AST_SC_ANALOG: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && single_channel_variant && analog_cmd_mode && a1_r == a4_r |=> pwr1_r == 0)
    else $error("sc analog feedback not ain4");
  AST_DUAL_FB: assert property (@(posedge clk_sys) disable iff (rst)
    tick_r && !single_channel_variant && analog_cmd_mode && a2_r == a4_r |=> pwr2_r == 0)
    else $error("dual analog feedback not ain4");
  AST_LED_DARK: assert property (@(posedge clk_sys) disable iff (rst)
    !enc_fault_r |=> !led_r) else $error("led while healthy");
  AST_LED_TOGGLE: assert property (@(posedge clk_sys) disable iff (rst)
    enc_fault_r && fl_cnt_r == 32'(FLASH_HALF_CYC - 1) |=> led_r != $past(led_r))
    else $error("led did not toggle");
  // main scenarios: stall fault, pin stop, button stop, reverse drive, flashing
  COV_FAULT: cover property (@(posedge clk_sys) disable iff (rst) $rose(enc_fault_r));
  COV_ESTOP: cover property (@(posedge clk_sys) disable iff (rst) $rose(es_s[1]));
  COV_BTN: cover property (@(posedge clk_sys) disable iff (rst) $rose(bp_s[1] && bs_s[1]));
  COV_DRIVE: cover property (@(posedge clk_sys) disable iff (rst) pwr1_r < 0);
  COV_LED: cover property (@(posedge clk_sys) disable iff (rst) $rose(led_r));
endmodule

// ==== sim/motor_model.sv ====
module motor_model (
  input  wire logic              clk_sys,
  input  wire logic signed [7:0] pwr,
  input  wire logic              stall,
  output logic                   motion
);
  timeunit 1ns;
  timeprecision 1ps;
  // encoder toggles while powered; a seized shaft gives no edges at all
  always_ff @(posedge clk_sys) begin
    motion <= (pwr != 8'sh00) && !stall && !motion;
  end
endmodule

// ==== sim/test_position_servo_fault_supervisor.sv ====
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module test_position_servo_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run small; the tick-period and led-flash checks derive from these
  localparam int     PC = 20;
  localparam int     FH = 4;
  logic              clk_sys = 1'b0, rst = 1'b1, sc = 1'b0, an = 1'b0;
  logic              stall = 1'b0, estop = 1'b0, bp = 1'b0, bs = 1'b0;
  logic signed [7:0] a1 = 8'h00, a2 = 8'h00, a3 = 8'h00, a4 = 8'h00, d1 = 8'h00, d2 = 8'h00;
  logic [7:0]        g = 8'h01;
  logic              m1, m2, en, flt, led, tk, l;
  logic signed [7:0] p1, p2, ex;
  int                miscompares = 0, n_tests = 0, n;

  position_servo_fault_supervisor #(.PERIOD_CYC(PC), .FLASH_HALF_CYC(FH)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .single_channel_variant(sc), .analog_cmd_mode(an),
    .ain1(a1), .ain2(a2), .ain3(a3), .ain4(a4), .dest1(d1), .dest2(d2), .gain(g),
    .enc1_motion(m1), .enc2_motion(m2), .estop_in(estop), .btn_program(bp), .btn_set(bs),
    .pwr1_r(p1), .pwr2_r(p2), .motors_en_r(en), .enc_fault_r(flt), .led_r(led), .tick_r(tk));
  motor_model mm1 (.clk_sys(clk_sys), .pwr(p1), .stall(stall), .motion(m1));
  motor_model mm2 (.clk_sys(clk_sys), .pwr(p2), .stall(stall), .motion(m2));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic signed [7:0] expp(input logic signed [7:0] c, f, input logic [7:0] k);
    int v;
    v = (int'(c) - int'(f)) * int'(k);
    if (v > 127) v = 127;
    if (v < -127) v = -127;
    return v[7:0];
  endfunction
  // positions stay well inside the sensor span so every target is reachable
  function automatic logic signed [7:0] rnd();
    int v;
    v = int'($urandom_range(200)) - 100;
    return v[7:0];
  endfunction

  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // looks just after the edge so the registered pulse is settled; a missing tick is a miss
  task automatic tick();
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_sys);
      #1;
      if (tk === 1'b1) break;
    end
    if (i == 100) miscompares++;
  endtask
  // two ticks: inputs pass the synchronisers before the second one samples
  task automatic settle();
    tick();
    tick();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic drive(input logic signed [7:0] v1, v2, v3, v4, v5, v6, input logic [7:0] k);
    @(posedge clk_sys);
    d1 <= v1; d2 <= v2; a1 <= v3; a2 <= v4; a3 <= v5; a4 <= v6; g <= k;
  endtask

  initial begin
    void'($urandom(73));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    tick();
    n = 0;
    do begin @(posedge clk_sys); #1; n++; end while (tk !== 1'b1);
    `CHK("tick period", PC, n)
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      sc <= m[1];
      an <= m[0];
      for (int i = 0; i < 6; i++) begin
        if (i == 0) drive(8'sh05, 8'sh05, 8'sh05, 8'sh05, 8'sh05, 8'sh05, 8'h03);
        else drive(rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), 8'($urandom_range(3)));
        settle();
        ex = expp(an ? a1 : d1, sc ? (an ? a4 : a1) : (an ? a3 : a1), g);
        `CHK("pwr1", ex, p1)
        `CHK("pwr2", sc ? 8'sh00 : expp(an ? a2 : d2, an ? a4 : a2, g), p2)
      end
    end
    @(posedge clk_sys);
    sc <= 1'b0;
    an <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      drive(8'sh32, 8'shCE, 8'sh00, 8'sh00, 8'sh00, 8'sh00, 8'h01);
      settle();
      `CHK("drive on", 1'b1, en)
      @(posedge clk_sys);
      if (k == 0) estop <= 1'b1;
      else begin bp <= 1'b1; bs <= 1'b1; end
      settle();
      `CHK("stop pwr1", 8'sh00, p1)
      `CHK("stop pwr2", 8'sh00, p2)
      `CHK("stop en", 1'b0, en)
      @(posedge clk_sys);
      estop <= 1'b0; bp <= 1'b0; bs <= 1'b0;
      settle();
      `CHK("resume", 8'sh32, p1)
    end
    // 31 sits just under the stall threshold; the negative case checks magnitude
    for (int s = 0; s < 3; s++) begin
      @(posedge clk_sys);
      stall <= 1'b1;
      drive(s == 0 ? 8'sh1F : (s == 1 ? 8'shE0 : 8'sh28), s == 2 ? 8'shD8 : 8'sh00,
            8'sh00, 8'sh00, 8'sh00, 8'sh00, 8'h01);
      settle();
      settle();
      `CHK("fault", s != 0, flt)
      if (s != 0) begin
        `CHK("halt", 8'sh00, p1)
        `CHK("halt2", 8'sh00, p2)
        l = led;
        n = 0;
        while (led === l && n < 4 * FH) begin @(posedge clk_sys); #1; n++; end
        `CHK("led flash", ~l, led)
        @(posedge clk_sys);
        stall <= 1'b0;
        settle();
        `CHK("fault held", 1'b1, flt)
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK("fault cleared", 1'b0, flt)
      end
    end
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
endmodule
